// file: pkg/ivt_defines.svh
// Offsets, field positions, reset values and sizes of the interrupt vector table block.
`ifndef IVT_DEFINES_SVH
`define IVT_DEFINES_SVH

// =====================================================================
// Table geometry
`define IVT_NUM_SRC 68
`define IVT_ADDR_W 21
`define IVT_BASE_RST 21'h000008
`define IVT_LOW_OFS 21'h000010
`define IVT_ISR_SHIFT 2
`define IVT_FLASH_END 21'h010000
`define IVT_SAF_BASE 21'h00FF80

// =====================================================================
// Register byte offsets
`define IVT_REG_CTRL 8'h00
`define IVT_REG_BASE 8'h04
`define IVT_REG_CAPT 8'h08
`define IVT_REG_RSTAT 8'h0C
`define IVT_REG_PRIO0 8'h10
`define IVT_REG_PRIO1 8'h14
`define IVT_REG_PRIO2 8'h18
`define IVT_REG_ISR 8'h1C
`define IVT_REG_STAT 8'h20

// =====================================================================
// Fields, reset values and bus answers
`define IVT_CTRL_VME 0
`define IVT_CTRL_SAE 1
`define IVT_CTRL_RST 2'h0
`define IVT_RSTAT_EVF 0
`define IVT_RESP_OKAY 2'h0
`define IVT_RESP_SLVERR 2'h2

`endif

// file: pkg/ivt_int_if.sv
// Internal carrier between the vector table top, arbiter and range checker.
`timescale 1ns/100ps
`include "ivt_defines.svh"
interface ivt_int_if;
	import ivt_pkg::*;
	logic [`IVT_NUM_SRC-1:0] pend;
	logic [`IVT_NUM_SRC-1:0] prio;
	logic win_valid;
	logic win_high;
	ivt_vnum_t win_num;
	ivt_addr_t chk_addr;
	logic chk_sae;
	logic chk_ok;
	modport arb (input pend, input prio, output win_valid, output win_high, output win_num);
	modport chk (input chk_addr, input chk_sae, output chk_ok);
	modport top (output pend, output prio, output chk_addr, output chk_sae,
		input win_valid, input win_high, input win_num, input chk_ok);
endinterface

// file: pkg/ivt_pkg.sv
// Types shared by the interrupt vector table modules.
package ivt_pkg;
	typedef logic [20:0] ivt_addr_t;
	typedef logic [6:0] ivt_vnum_t;
	// Gray sequence along idle, fetch, serve.
	typedef enum logic [1:0] {
		IVT_IDLE = 2'h0,
		IVT_FETCH = 2'h1,
		IVT_SERVE = 2'h3,
		IVT_FAULT = 2'h2
	} ivt_state_t;
endpackage

// file: src/ivt_arb.sv
// Picks the pending source to serve: high priority first, then lowest vector number.
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_arb
	import ivt_pkg::*;
(
	// Carrier
	ivt_int_if.arb bus
);
	logic [`IVT_NUM_SRC-1:0] hi_req;
	logic [`IVT_NUM_SRC-1:0] lo_req;
	logic use_hi;
	logic [`IVT_NUM_SRC-1:0] sel_req;
	ivt_vnum_t pick;

	// =====================================================================
	// Split the pending sources by their software priority level.
	genvar gi;
	generate
		for (gi = 0; gi < `IVT_NUM_SRC; gi++) begin : g_src
			assign hi_req[gi] = bus.pend[gi] & bus.prio[gi];
			assign lo_req[gi] = bus.pend[gi] & ~bus.prio[gi];
		end
	endgenerate

	// Priority chooses the winner and, in legacy mode, which vector of the pair it gets.
	assign use_hi = |hi_req;
	assign sel_req = use_hi ? hi_req : lo_req;

	// Lowest numbered request wins within a level.
	always_comb begin
		pick = 7'h00;
		for (int i = `IVT_NUM_SRC - 1; i >= 0; i--) begin
			if (sel_req[i]) begin
				pick = ivt_vnum_t'(i);
			end
		end
	end

	assign bus.win_valid = |bus.pend;
	assign bus.win_high = use_hi;
	assign bus.win_num = pick;
endmodule

// file: src/ivt_chk.sv
// Decides whether a two-byte program location lies in executable flash.
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_chk
	import ivt_pkg::*;
(
	// Carrier
	ivt_int_if.chk bus
);
	ivt_addr_t last_byte;
	logic in_flash;
	logic in_saf;

	// Both bytes of the word must be fetchable, so test the upper one too.
	assign last_byte = bus.chk_addr + 21'h000001;
	assign in_flash = (last_byte < `IVT_FLASH_END) && (last_byte > bus.chk_addr);
	// Storage area flash is data only while it is enabled.
	assign in_saf = bus.chk_sae && (last_byte >= `IVT_SAF_BASE);
	assign bus.chk_ok = in_flash && !in_saf;
endmodule

// file: src/ivt_top.sv
// Interrupt vector table: vector address generation, capture and fetch guard.
//
// Summary of operation
// - One table entry per each of 68 sources.
// - Table lives in program memory at programmable base.
// - Control bit selects vectored table or legacy pair.
// - Entries are 16-bit words, two bytes each.
// - Legacy: high at base, low at base+16.
// - Base resets to 0x000008, low vector 0x000018.
// - Legacy vector locations hold jump instructions.
// - Vectored entry address is base plus twice number.
// - Routine address is entry shifted left two.
// - Computed vector address captured on each interrupt.
// - Software priority picks among concurrent requests and selects the legacy vector.
// - Failed fetch resets system, clears violation flag.
// - Fault when entry or routine is non-executable.
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_top
	import ivt_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Interrupt sources, same clock
	input wire logic [`IVT_NUM_SRC-1:0] irq_i,
	// Core handshake
	output logic int_req_o,
	output logic int_high_o,
	input wire logic int_ack_i,
	output logic isr_valid_o,
	output logic [20:0] isr_addr_o,
	output logic isr_jump_o,
	// Vector fetch from program flash
	output logic fetch_req_o,
	output logic [20:0] fetch_addr_o,
	input wire logic fetch_valid_i,
	input wire logic [15:0] fetch_data_i,
	// System reset request
	output logic sys_reset_o
);
	// =====================================================================
	// Declarations
	ivt_int_if ibus ();

	logic aw_have_r;
	logic [7:0] aw_addr_r;
	logic w_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	logic [1:0] ctrl_r;
	ivt_addr_t base_r;
	ivt_addr_t capt_r;
	ivt_addr_t isr_r;
	logic evf_r;
	logic [`IVT_NUM_SRC-1:0] prio_r;
	ivt_state_t state_r;
	ivt_state_t state_nxt;
	ivt_vnum_t num_r;
	logic jump_r;
	ivt_addr_t fetch_addr_r;

	logic aw_take;
	logic w_take;
	logic wr_fire;
	logic wr_hit;
	logic ar_take;
	logic rd_hit;
	logic [31:0] rd_word;
	logic [31:0] wr_mask;
	logic wr_ctrl;
	logic wr_base;
	logic wr_rstat;
	logic wr_prio0;
	logic wr_prio1;
	logic wr_prio2;
	logic [31:0] ctrl_m;
	logic [31:0] base_m;
	logic [31:0] prio0_m;
	logic [31:0] prio1_m;
	logic [31:0] prio2_m;
	logic [31:0] rstat_m;

	logic vme;
	logic take;
	ivt_addr_t vec_addr;
	ivt_addr_t leg_addr;
	ivt_addr_t tab_addr;
	ivt_addr_t isr_calc;
	logic fault_now;

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] ivt_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] mask_v);
		ivt_merge = (old_v & ~mask_v) | (new_v & mask_v);
	endfunction

	// =====================================================================
	// Submodules
	ivt_arb u_arb (
		.bus (ibus)
	);

	ivt_chk u_chk (
		.bus (ibus)
	);

	// =====================================================================
	// AXI4-Lite write path
	// Address and data are accepted in any order; a new write waits for B.
	assign s_axi_awready_o = !aw_have_r && !bvalid_r;
	assign s_axi_wready_o = !w_have_r && !bvalid_r;
	assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take = s_axi_wvalid_i && s_axi_wready_o;
	assign wr_fire = aw_have_r && w_have_r;
	assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

	// Write decode.
	assign wr_ctrl = wr_fire && (aw_addr_r == `IVT_REG_CTRL);
	assign wr_base = wr_fire && (aw_addr_r == `IVT_REG_BASE);
	assign wr_rstat = wr_fire && (aw_addr_r == `IVT_REG_RSTAT);
	assign wr_prio0 = wr_fire && (aw_addr_r == `IVT_REG_PRIO0);
	assign wr_prio1 = wr_fire && (aw_addr_r == `IVT_REG_PRIO1);
	assign wr_prio2 = wr_fire && (aw_addr_r == `IVT_REG_PRIO2);
	// Read-only registers answer OKAY and ignore the data.
	assign wr_hit = wr_ctrl || wr_base || wr_rstat || wr_prio0 || wr_prio1 || wr_prio2
		|| (aw_addr_r == `IVT_REG_CAPT) || (aw_addr_r == `IVT_REG_ISR)
		|| (aw_addr_r == `IVT_REG_STAT);

	// Merged values of the writable registers.
	assign ctrl_m = ivt_merge({30'h0, ctrl_r}, w_data_r, wr_mask);
	assign base_m = ivt_merge({11'h0, base_r}, w_data_r, wr_mask);
	assign rstat_m = ivt_merge({31'h0, evf_r}, w_data_r, wr_mask);
	assign prio0_m = ivt_merge(prio_r[31:0], w_data_r, wr_mask);
	assign prio1_m = ivt_merge(prio_r[63:32], w_data_r, wr_mask);
	assign prio2_m = ivt_merge({28'h0, prio_r[67:64]}, w_data_r, wr_mask);

	// Holding registers and write response.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `IVT_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr_i[7:2], 2'h0};
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? `IVT_RESP_OKAY : `IVT_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;

	// =====================================================================
	// AXI4-Lite read path
	assign s_axi_arready_o = !rvalid_r;
	assign ar_take = s_axi_arvalid_i && s_axi_arready_o;

	// Read selection; the status word shows the live machine state.
	assign rd_word =
		(s_axi_araddr_i[7:2] == `IVT_REG_CTRL >> 2) ? {30'h0, ctrl_r} :
		(s_axi_araddr_i[7:2] == `IVT_REG_BASE >> 2) ? {11'h0, base_r} :
		(s_axi_araddr_i[7:2] == `IVT_REG_CAPT >> 2) ? {11'h0, capt_r} :
		(s_axi_araddr_i[7:2] == `IVT_REG_RSTAT >> 2) ? {31'h0, evf_r} :
		(s_axi_araddr_i[7:2] == `IVT_REG_PRIO0 >> 2) ? prio_r[31:0] :
		(s_axi_araddr_i[7:2] == `IVT_REG_PRIO1 >> 2) ? prio_r[63:32] :
		(s_axi_araddr_i[7:2] == `IVT_REG_PRIO2 >> 2) ? {28'h0, prio_r[67:64]} :
		(s_axi_araddr_i[7:2] == `IVT_REG_ISR >> 2) ? {11'h0, isr_r} :
		(s_axi_araddr_i[7:2] == `IVT_REG_STAT >> 2) ? {23'h0, state_r, num_r} :
		32'h0000_0000;
	assign rd_hit = (s_axi_araddr_i[7:2] <= (`IVT_REG_STAT >> 2));

	// Read data register held until the master takes it.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `IVT_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= rd_hit ? `IVT_RESP_OKAY : `IVT_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;

	// =====================================================================
	// Software registers
	// A violation clears the flag even if software sets it that same cycle,
	// so a reset cause is never masked by a racing write.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_r <= `IVT_CTRL_RST;
			base_r <= `IVT_BASE_RST;
			evf_r <= 1'b1;
			prio_r <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= ctrl_m[1:0];
			end
			if (wr_base) begin
				base_r <= base_m[20:0];
			end
			if (fault_now) begin
				evf_r <= 1'b0;
			end else if (wr_rstat) begin
				evf_r <= rstat_m[`IVT_RSTAT_EVF];
			end
			if (wr_prio0) begin
				prio_r[31:0] <= prio0_m;
			end
			if (wr_prio1) begin
				prio_r[63:32] <= prio1_m;
			end
			if (wr_prio2) begin
				prio_r[67:64] <= prio2_m[3:0];
			end
		end
	end

	// =====================================================================
	// Vector address computation
	assign vme = ctrl_r[`IVT_CTRL_VME];
	assign ibus.pend = irq_i;
	assign ibus.prio = prio_r;
	assign ibus.chk_sae = ctrl_r[`IVT_CTRL_SAE];

	// Legacy pair: base for high level, eight words up for low level.
	assign leg_addr = ibus.win_high ? base_r : base_r + `IVT_LOW_OFS;
	// Each entry is one word, two bytes; an odd base is not guarded.
	assign tab_addr = base_r + {13'h0, ibus.win_num, 1'b0};
	assign vec_addr = vme ? tab_addr : leg_addr;
	// Routine address from the fetched word.
	assign isr_calc = ivt_addr_t'(fetch_data_i) << `IVT_ISR_SHIFT;

	// One checker serves both the entry and the routine it names.
	assign ibus.chk_addr = (state_r == IVT_FETCH) ? isr_calc : vec_addr;

	assign take = int_req_o && int_ack_i;
	assign fault_now = (state_r == IVT_FAULT);

	// =====================================================================
	// Interrupt sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			IVT_IDLE: begin
				if (take) begin
					if (!ibus.chk_ok) begin
						state_nxt = IVT_FAULT;
					end else if (vme) begin
						state_nxt = IVT_FETCH;
					end else begin
						state_nxt = IVT_SERVE;
					end
				end
			end
			IVT_FETCH: begin
				if (fetch_valid_i) begin
					state_nxt = ibus.chk_ok ? IVT_SERVE : IVT_FAULT;
				end
			end
			IVT_SERVE: begin
				state_nxt = IVT_IDLE;
			end
			IVT_FAULT: begin
				state_nxt = IVT_IDLE;
			end
			default: begin
				state_nxt = IVT_IDLE;
			end
		endcase
	end

	// Capture, fetch address and routine address registers.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= IVT_IDLE;
			capt_r <= 21'h000000;
			isr_r <= 21'h000000;
			num_r <= 7'h00;
			jump_r <= 1'b0;
			fetch_addr_r <= 21'h000000;
		end else begin
			state_r <= state_nxt;
			if (take) begin
				capt_r <= vec_addr;
				num_r <= ibus.win_num;
				fetch_addr_r <= vec_addr;
				// Legacy locations hold a jump the core runs itself.
				jump_r <= !vme;
				if (!vme) begin
					isr_r <= vec_addr;
				end
			end
			if ((state_r == IVT_FETCH) && fetch_valid_i) begin
				isr_r <= isr_calc;
			end
		end
	end

	// =====================================================================
	// Outputs to the core and flash
	// No new request is offered while one is being resolved.
	assign int_req_o = (state_r == IVT_IDLE) && ibus.win_valid;
	assign int_high_o = ibus.win_high;
	assign isr_valid_o = (state_r == IVT_SERVE);
	assign isr_addr_o = isr_r;
	assign isr_jump_o = jump_r;
	assign fetch_req_o = (state_r == IVT_FETCH);
	assign fetch_addr_o = fetch_addr_r;
	assign sys_reset_o = fault_now;
endmodule

// file: tb/ivt_core_model.sv
// Behavioural core and program flash facing the vector table.
`timescale 1ns/100ps
module ivt_core_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Bench control
	input wire logic ack_en_i,
	input wire logic [3:0] lat_i,
	// Core and flash
	output logic int_ack_o,
	input wire logic fetch_req_i,
	input wire logic [20:0] fetch_addr_i,
	output logic fetch_valid_o,
	output logic [15:0] fetch_data_o
);
	// ====
	// Flash words by word address, loaded by the bench.
	logic [15:0] mem [0:1023];
	logic [3:0] wait_r;

	// Answer after lat_i waits; the data bus toggles otherwise so stale words never pass.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			int_ack_o <= 1'b0;
			fetch_valid_o <= 1'b0;
			fetch_data_o <= 16'h0000;
			wait_r <= 4'h0;
		end else begin
			int_ack_o <= ack_en_i;
			fetch_valid_o <= 1'b0;
			fetch_data_o <= ~fetch_data_o;
			if (fetch_req_i && !fetch_valid_o) begin
				wait_r <= wait_r + 4'h1;
				if (wait_r == lat_i) begin
					fetch_valid_o <= 1'b1;
					fetch_data_o <= mem[fetch_addr_i[10:1]];
					wait_r <= 4'h0;
				end
			end
		end
	end
endmodule

// file: tb/ivt_top_asserts.sv
// Port checks of the interrupt vector table.
`timescale 1ns/100ps
`include "ivt_defines.svh"
module ivt_top_asserts
	import ivt_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Sources and core
	input wire logic [`IVT_NUM_SRC-1:0] irq_i,
	input wire logic int_req_o,
	input wire logic int_ack_i,
	input wire logic isr_valid_o,
	input wire logic [20:0] isr_addr_o,
	input wire logic isr_jump_o,
	// Fetch and reset request
	input wire logic fetch_req_o,
	input wire logic [20:0] fetch_addr_o,
	input wire logic fetch_valid_i,
	input wire logic [15:0] fetch_data_i,
	input wire logic sys_reset_o
);
	// ====
	// Properties
	// One domain, so clock and reset are given once.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	a_req_cause: assert property (int_req_o |-> |irq_i)
		else $error("offer without source");
	a_take_answer: assert property (int_req_o && int_ack_i |=>
		fetch_req_o || isr_valid_o || sys_reset_o) else $error("no answer to take");
	a_fetch_hold: assert property (fetch_req_o && !fetch_valid_i |=>
		fetch_req_o && $stable(fetch_addr_o)) else $error("fetch dropped");
	a_even_entry: assert property (fetch_req_o |-> !fetch_addr_o[0])
		else $error("odd entry");
	a_route_shift: assert property (fetch_req_o && fetch_valid_i |=>
		sys_reset_o || isr_addr_o == {3'h0, $past(fetch_data_i), 2'h0})
		else $error("bad routine");
	a_jump_kind: assert property (isr_valid_o |->
		isr_jump_o == !$past(fetch_req_o)) else $error("bad jump flag");
	// Serve and fault are single pulses, then the block is idle again.
	a_pulse_once: assert property (isr_valid_o || sys_reset_o |=>
		!(isr_valid_o || sys_reset_o || fetch_req_o)) else $error("long pulse");
	a_exec_target: assert property (isr_valid_o |->
		isr_addr_o < `IVT_FLASH_END - 21'h1) else $error("served outside flash");
endmodule

bind ivt_top ivt_top_asserts u_ivt_chk (.clock_i, .rst_i, .irq_i, .int_req_o, .int_ack_i,
	.isr_valid_o, .isr_addr_o, .isr_jump_o, .fetch_req_o, .fetch_addr_o, .fetch_valid_i,
	.fetch_data_i, .sys_reset_o);

// file: tb/tb_top.sv
// Self-checking bench for the interrupt vector table.
`timescale 1ns/100ps
`include "ivt_defines.svh"
`define CHK(g, e, m) \
	begin \
		num_checks++; \
		if ((g) !== (e)) begin \
			error_cnt++; \
			$display("CHECK FAILED %0t %s", $time, m); \
		end \
	end
module tb_top;
	// ====
	// Signals and mirror
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
	logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, ack_en = 1'b0;
	logic [31:0] w_d = 32'h0, r_d, q;
	logic [67:0] irq = '0, prio_m = '0;
	logic [3:0] lat = 4'h0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, int_req, int_high, int_ack, isr_v, isr_j;
	logic f_req, f_v, sys_rst, flag_m = 1'b1;
	logic [1:0] b_resp, r_resp, r, ctrl_m = 2'h0;
	logic [20:0] isr_a, f_a, base_m = `IVT_BASE_RST, capt_m = 21'h0;
	logic [15:0] f_d;
	logic [6:0] vnum_m = 7'h0;
	int error_cnt = 0, num_checks = 0;

	// A 4 ns clock.
	always #2 clock_i = ~clock_i;

	ivt_top DUT (.clock_i, .rst_i, .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v),
		.s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF),
		.s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp),
		.s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_araddr_i(ar_a),
		.s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d),
		.s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .irq_i(irq),
		.int_req_o(int_req), .int_high_o(int_high), .int_ack_i(int_ack), .isr_valid_o(isr_v),
		.isr_addr_o(isr_a), .isr_jump_o(isr_j), .fetch_req_o(f_req), .fetch_addr_o(f_a),
		.fetch_valid_i(f_v), .fetch_data_i(f_d), .sys_reset_o(sys_rst));
	ivt_core_model core (.clock_i, .rst_i, .ack_en_i(ack_en), .lat_i(lat), .int_ack_o(int_ack),
		.fetch_req_i(f_req), .fetch_addr_i(f_a), .fetch_valid_o(f_v), .fetch_data_o(f_d));

	// Expected register word from the mirror.
	function automatic logic [31:0] mir(input logic [7:0] a);
		case (a)
			8'h00: return {30'h0, ctrl_m};
			8'h04: return {11'h0, base_m};
			8'h08: return {11'h0, capt_m};
			8'h0C: return {31'h0, flag_m};
			8'h10: return prio_m[31:0];
			8'h14: return prio_m[63:32];
			8'h18: return {28'h0, prio_m[67:64]};
			8'h20: return {25'h0, vnum_m};
			default: return 32'h0;
		endcase
	endfunction

	// One bus access; each valid drops when taken, and the answer is awaited for as long
	// as it takes, so only the watchdog can cut this wait short.
	task axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
		bit ad, dd, done;
		@(posedge clock_i);
		ad = 1'b0;
		dd = !wr;
		done = 1'b0;
		aw_a <= a;
		ar_a <= a;
		w_d <= d;
		aw_v <= wr;
		w_v <= wr;
		b_r <= wr;
		ar_v <= !wr;
		r_r <= !wr;
		while (!done) begin
			@(posedge clock_i);
			if (!ad && (wr ? aw_rdy : ar_rdy)) begin
				ad = 1'b1;
				aw_v <= 1'b0;
				ar_v <= 1'b0;
			end
			if (!dd && w_rdy) begin
				dd = 1'b1;
				w_v <= 1'b0;
			end
			if (wr ? b_v : r_v) begin
				done = 1'b1;
				q = r_d;
				r = wr ? b_resp : r_resp;
				b_r <= 1'b0;
				r_r <= 1'b0;
			end
		end
		`CHK(done, 1'b1, "bus answer")
	endtask

	// Read and compare with the mirror.
	task rd(input logic [7:0] a);
		axi(1'b0, a, 32'h0);
		`CHK(q, mir(a), "read data")
		`CHK(r, (a > 8'h20) ? 2'h2 : 2'h0, "read answer")
	endtask

	// Write, update the mirror, read back.
	task wr(input logic [7:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
		`CHK(r, (a > 8'h20) ? 2'h2 : 2'h0, "write answer")
		case (a)
			8'h00: ctrl_m = d[1:0];
			8'h04: base_m = d[20:0];
			8'h0C: flag_m = flag_m | d[0];
			8'h10: prio_m[31:0] = d;
			8'h14: prio_m[63:32] = d;
			8'h18: prio_m[67:64] = d[3:0];
			default: ;
		endcase
		rd(a);
	endtask

	// Offer sources a and b (b < 0: none) and check vector, routine, capture and fault.
	task serve(input int a, input int b, input logic [15:0] ent);
		int win, loc, isr, lim, n;
		bit bad;
		win = a;
		if (b >= 0 && (prio_m[b] > prio_m[a] || (prio_m[b] == prio_m[a] && b < a))) win = b;
		loc = base_m + (prio_m[win] ? 0 : 16);
		if (ctrl_m[0]) loc = base_m + 2 * win;
		isr = ctrl_m[0] ? ent * 4 : loc;
		lim = ctrl_m[1] ? `IVT_SAF_BASE : `IVT_FLASH_END;
		bad = loc + 1 >= lim || isr + 1 >= lim;
		core.mem[loc[10:1]] = ent;
		@(posedge clock_i);
		irq <= (68'h1 << a) | (b < 0 ? 68'h0 : 68'h1 << b);
		ack_en <= 1'b1;
		lat <= 4'($urandom % 4);
		for (n = 0; n < 20 && !(int_req && int_ack); n++) @(negedge clock_i);
		`CHK(int_high, prio_m[win], "priority level")
		@(posedge clock_i);
		irq <= '0;
		ack_en <= 1'b0;
		for (n = 0; n < 40 && !(isr_v || sys_rst); n++) begin
			@(negedge clock_i);
			if (f_req) `CHK(f_a, 21'(loc), "entry address")
		end
		`CHK(sys_rst, bad, "fault request")
		if (!bad) begin
			`CHK(isr_v, 1'b1, "routine ready")
			`CHK(isr_a, 21'(isr), "routine address")
			`CHK(isr_j, !ctrl_m[0], "jump kind")
		end
		capt_m = 21'(loc);
		vnum_m = 7'(win);
		flag_m = flag_m & !bad;
		rd(8'h08);
		rd(8'h0C);
		rd(8'h20);
		if (bad) wr(8'h0C, 32'h1);
	endtask

	// Verdict and end of run.
	task finish_test();
		if (error_cnt == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Cut a hang short, far beyond the expected run.
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end

	// Main sequence: reset values, legacy pair, vectored table, faults.
	initial begin
		void'($urandom(58));
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		for (int a = 0; a <= 'h24; a += 4) rd(8'(a));
		wr(8'h28, 32'hFFFFFFFF);
		wr(8'h08, 32'h00001234);
		wr(8'h10, 32'h00000020);
		serve(9, 5, 16'h0000);
		serve(12, 9, 16'h0000);
		wr(8'h18, 32'h00000004);
		serve(40, 66, 16'h0000);
		wr(8'h00, 32'h00000001);
		serve(0, -1, 16'h0010);
		serve(67, -1, 16'h3FDF);
		// Even bases kept inside flash, as software must.
		repeat (10) begin
			wr(8'h04, ($urandom % 512) * 2 + 2);
			serve($urandom % 68, $urandom % 68, 16'($urandom) & 16'h3FFF);
		end
		serve(3, -1, 16'h4000);
		wr(8'h00, 32'h00000003);
		serve(3, -1, 16'h3FE0);
		wr(8'h04, 32'h0000FFF0);
		serve(67, -1, 16'h0100);
		wr(8'h00, 32'h00000000);
		serve(3, -1, 16'h0000);
		finish_test();
	end
endmodule
